// *** rtl/dpwi_pkg.sv ***
package dpwi_pkg;

   // command word bit positions
   localparam int CMD_ON1       = 0;
   localparam int CMD_ON2       = 1;
   localparam int CMD_ON3       = 2;
   localparam int CMD_NO_COAST  = 3;
   localparam int CMD_RAMP      = 4;
   localparam int CMD_USE_RAMP  = 5;
   localparam int CMD_START     = 6;
   localparam int CMD_RESET     = 7;
   localparam int CMD_JOG1      = 8;
   localparam int CMD_JOG2      = 9;
   localparam int CMD_VALID     = 10;
   localparam int CMD_SLOW      = 11;
   localparam int CMD_CATCH     = 12;
   localparam int CMD_SETUP_LSB = 13;
   localparam int CMD_SETUP_MSB = 14;
   localparam int CMD_REVERSE   = 15;

   // state word bit positions
   localparam int ST_CTRL_READY  = 0;
   localparam int ST_DRIVE_READY = 1;
   localparam int ST_ENABLE      = 2;
   localparam int ST_TRIP        = 3;
   localparam int ST_ON2         = 4;
   localparam int ST_ON3         = 5;
   localparam int ST_INHIBIT     = 6;
   localparam int ST_WARNING     = 7;
   localparam int ST_AT_REF      = 8;
   localparam int ST_BUS_CTRL    = 9;
   localparam int ST_FREQ_OK     = 10;
   localparam int ST_IN_OPER     = 11;
   localparam int ST_AUTOSTOP    = 12;
   localparam int ST_VOLTAGE     = 13;
   localparam int ST_TORQUE      = 14;
   localparam int ST_TIMER       = 15;

   // reset values
   localparam logic [15:0] CMD_RESET_VALUE   = 16'h0000;
   localparam logic [15:0] STATE_RESET_VALUE = 16'h0000;
   localparam logic        INHIBIT_RESET     = 1'b1;
   localparam logic [1:0]  SETUP_RESET       = 2'h0;

   // thermal protection limit in percent
   localparam logic [7:0]  THERMAL_LIMIT_PCT = 8'h64;

   // how a bus bit combines with its digital input
   typedef enum logic [1:0] {
      DPWI_SRC_DIGITAL,
      DPWI_SRC_SERIAL,
      DPWI_SRC_OR,
      DPWI_SRC_AND
   } dpwi_src_t;

   // configuration settings of the drive
   typedef struct packed {
      dpwi_src_t        coast_src;
      dpwi_src_t        quick_src;
      dpwi_src_t        start_src;
      dpwi_src_t        reverse_src;
      dpwi_src_t        setup_src;
      logic             multi_setup;
      logic             stop_relay_en;
      logic [3:0][1:0]  setup_link_select;
      logic signed [15:0] warn_speed_low;
      logic signed [15:0] warn_speed_high;
   } dpwi_config_t;

   // digital inputs, active high
   typedef struct packed {
      logic       coast_ok;
      logic       quick_ok;
      logic       start;
      logic       reverse;
      logic [1:0] setup;
   } dpwi_din_t;

   // status reported by the motor control
   typedef struct packed {
      logic               fault_event;
      logic               control_ready;
      logic               power_ready;
      logic               warning;
      logic               speed_at_ref;
      logic               remote_site;
      logic               local_keypad_stop;
      logic               local_site_sel;
      logic               at_zero_freq;
      logic               overload_stop;
      logic               voltage_exceeded;
      logic               torque_exceeded;
      logic signed [15:0] output_freq;
      logic [7:0]         motor_thermal_pct;
      logic [7:0]         conv_thermal_pct;
   } dpwi_drive_t;

   // commands handed to the motor control
   typedef struct packed {
      logic       run_enable;
      logic       coast_stop;
      logic       quick_stop;
      logic       ramp_stop;
      logic       hold_freq;
      logic       fault_reset;
      logic       jog1;
      logic       jog2;
      logic       ref_down;
      logic       ref_up;
      logic       reverse;
      logic       stop_relay;
      logic [1:0] active_setup;
   } dpwi_ctrl_t;

endpackage

// *** rtl/dpwi_top.sv ***
`timescale 1ns/1ns
module dpwi_top
   import dpwi_pkg::*;
(
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic         cmd_strobe,
   input  wire logic [15:0]  drive_command_word,
   input  wire dpwi_config_t cfg,
   input  wire dpwi_din_t    din,
   input  wire dpwi_drive_t  drive,
   output logic [15:0]       drive_state_word,
   output logic              reply_strobe,
   output dpwi_ctrl_t        ctrl
);

   // combine a bus bit with its digital input
   function automatic logic src_combine(input dpwi_src_t mode, input logic bus_bit, input logic din_bit);
      logic r;
      r = din_bit;
      unique case (mode)
         DPWI_SRC_DIGITAL: r = din_bit;
         DPWI_SRC_SERIAL:  r = bus_bit;
         DPWI_SRC_OR:      r = bus_bit | din_bit;
         DPWI_SRC_AND:     r = bus_bit & din_bit;
      endcase
      return r;
   endfunction

   logic [15:0] cmd_reg;
   logic        accept;
   logic        reset_edge;
   logic        trip_reg;
   logic        inhibit_reg;
   logic        inhibit_next;
   logic        bus_ctrl_reg;
   logic [1:0]  setup_reg;
   logic [1:0]  setup_req;
   logic        setup_linked;
   logic        running;
   logic        coast_ok;
   logic        quick_ok;
   logic        start_ok;
   logic        ready_cmd;
   logic        jog_allowed;
   logic        any_stop;
   logic        freq_ok;
   logic        thermal_over;
   logic [15:0] state_next;

   // valid words only; bit 10 low leaves the active word untouched
   assign accept     = cmd_strobe & drive_command_word[CMD_VALID];
   assign reset_edge = accept & drive_command_word[CMD_RESET] & ~cmd_reg[CMD_RESET];

   // active command word
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cmd_reg <= CMD_RESET_VALUE;
      end else if (accept) begin
         cmd_reg <= drive_command_word;
      end
   end

   // trip latch; a new fault beats a reset in the same cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         trip_reg <= 1'b0;
      end else if (drive.fault_event) begin
         trip_reg <= 1'b1;
      end else if (reset_edge) begin
         trip_reg <= 1'b0;
      end
   end

   // combined start conditions
   assign coast_ok  = src_combine(cfg.coast_src, cmd_reg[CMD_NO_COAST], din.coast_ok);
   assign quick_ok  = src_combine(cfg.quick_src, cmd_reg[CMD_RAMP], din.quick_ok);
   assign start_ok  = src_combine(cfg.start_src, cmd_reg[CMD_START], din.start);
   assign ready_cmd = cmd_reg[CMD_ON1] & cmd_reg[CMD_ON2] & cmd_reg[CMD_ON3];
   assign jog_allowed = ~cmd_reg[CMD_RAMP] & (cmd_reg[CMD_NO_COAST:CMD_ON1] == 4'hF) & ~trip_reg;
   assign running   = ~drive.at_zero_freq;

   // start inhibit: set wins over clear
   always_comb begin
      inhibit_next = inhibit_reg;
      if (reset_edge | ~cmd_reg[CMD_ON2] | ~cmd_reg[CMD_ON3]) begin
         inhibit_next = 1'b1;
      end else if (~cmd_reg[CMD_ON1] & cmd_reg[CMD_ON2] & cmd_reg[CMD_ON3] & cmd_reg[CMD_VALID]) begin
         inhibit_next = 1'b0;
      end
   end

   // start inhibit register, set at power-up
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         inhibit_reg <= INHIBIT_RESET;
      end else begin
         inhibit_reg <= inhibit_next;
      end
   end

   // bus control flag; local action wins over acceptance
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         bus_ctrl_reg <= 1'b0;
      end else if (drive.local_keypad_stop | drive.local_site_sel) begin
         bus_ctrl_reg <= 1'b0;
      end else if (accept & drive.remote_site) begin
         bus_ctrl_reg <= 1'b1;
      end
   end

   // two-bit set-up request, low bit from bit 13, and link check
   assign setup_req    = {src_combine(cfg.setup_src, cmd_reg[CMD_SETUP_MSB], din.setup[1]),
                          src_combine(cfg.setup_src, cmd_reg[CMD_SETUP_LSB], din.setup[0])};
   assign setup_linked = (cfg.setup_link_select[setup_req] == setup_reg)
                       | (cfg.setup_link_select[setup_reg] == setup_req);

   // active set-up selection
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         setup_reg <= SETUP_RESET;
      end else if (cfg.multi_setup & (~running | setup_linked)) begin
         setup_reg <= setup_req;
      end
   end

   // drive commands, registered
   assign any_stop = ~cmd_reg[CMD_ON1] | ~cmd_reg[CMD_ON2] | ~cmd_reg[CMD_ON3] | ~start_ok;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctrl <= '0;
      end else begin
         ctrl.run_enable   <= ready_cmd & coast_ok & quick_ok & start_ok & ~trip_reg & ~inhibit_reg;
         ctrl.coast_stop   <= ~cmd_reg[CMD_ON2] | ~coast_ok | trip_reg;
         ctrl.quick_stop   <= ~cmd_reg[CMD_ON3] | ~quick_ok;
         ctrl.ramp_stop    <= ~cmd_reg[CMD_ON1] | ~start_ok;
         ctrl.hold_freq    <= ~cmd_reg[CMD_USE_RAMP];
         ctrl.fault_reset  <= reset_edge;
         ctrl.jog1         <= jog_allowed & cmd_reg[CMD_JOG1];
         ctrl.jog2         <= jog_allowed & cmd_reg[CMD_JOG2];
         ctrl.ref_down     <= cmd_reg[CMD_SLOW];
         ctrl.ref_up       <= cmd_reg[CMD_CATCH] & ~cmd_reg[CMD_SLOW];
         ctrl.reverse      <= src_combine(cfg.reverse_src, cmd_reg[CMD_REVERSE], din.reverse);
         ctrl.stop_relay   <= cfg.stop_relay_en & drive.at_zero_freq & (any_stop | ~quick_ok);
         ctrl.active_setup <= setup_reg;
      end
   end

   // state word contents
   assign freq_ok = (drive.output_freq >= cfg.warn_speed_low) & (drive.output_freq <= cfg.warn_speed_high);
   assign thermal_over = (drive.motor_thermal_pct > THERMAL_LIMIT_PCT) | (drive.conv_thermal_pct > THERMAL_LIMIT_PCT);
   always_comb begin
      state_next                 = STATE_RESET_VALUE;
      state_next[ST_CTRL_READY]  = ready_cmd & ~trip_reg & drive.control_ready;
      state_next[ST_DRIVE_READY] = ready_cmd & ~trip_reg & drive.control_ready & drive.power_ready;
      state_next[ST_ENABLE]      = ready_cmd & ~trip_reg;
      state_next[ST_TRIP]        = trip_reg;
      state_next[ST_ON2]         = cmd_reg[CMD_ON2];
      state_next[ST_ON3]         = cmd_reg[CMD_ON3];
      state_next[ST_INHIBIT]     = inhibit_reg;
      state_next[ST_WARNING]     = drive.warning;
      state_next[ST_AT_REF]      = drive.speed_at_ref;
      state_next[ST_BUS_CTRL]    = bus_ctrl_reg;
      state_next[ST_FREQ_OK]     = freq_ok;
      state_next[ST_IN_OPER]     = ctrl.run_enable | running;
      state_next[ST_AUTOSTOP]    = drive.overload_stop;
      state_next[ST_VOLTAGE]     = drive.voltage_exceeded;
      state_next[ST_TORQUE]      = drive.torque_exceeded;
      state_next[ST_TIMER]       = thermal_over;
   end

   // state word refreshed every cycle, reply marked after each telegram
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         drive_state_word <= STATE_RESET_VALUE;
         reply_strobe     <= 1'b0;
      end else begin
         drive_state_word <= state_next;
         reply_strobe     <= cmd_strobe;
      end
   end

   // checks
   sequence reset_request_s;
      accept && drive_command_word[CMD_RESET] && !cmd_reg[CMD_RESET];
   endsequence

   sequence reset_pulse_s;
      ctrl.fault_reset ##1 !ctrl.fault_reset;
   endsequence

   property invalid_word_p;
      @(posedge clk_sys) disable iff (rst)
      (cmd_strobe && !drive_command_word[CMD_VALID] && !accept) |=> $stable(cmd_reg);
   endproperty

   word_ignored_a: assert property (invalid_word_p) else $error("ignored word changed command");

   fault_reset_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
      reset_request_s |=> reset_pulse_s) else $error("fault reset pulse missing");

   no_reset_steady_a: assert property (@(posedge clk_sys) disable iff (rst)
      ctrl.fault_reset |-> $past(reset_edge)) else $error("fault reset without rising bit");

   trip_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
      (reset_edge && !drive.fault_event) |=> !trip_reg ##1 !drive_state_word[ST_TRIP] || trip_reg)
      else $error("trip not cleared by reset");

   trip_blocks_a: assert property (@(posedge clk_sys) disable iff (rst)
      ctrl.run_enable |-> !$past(trip_reg)) else $error("run enabled while tripped");

   jog_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
      (ctrl.jog1 || ctrl.jog2) |-> $past(!cmd_reg[CMD_RAMP] && cmd_reg[3:0] == 4'hF))
      else $error("jog outside permitted command");

   slow_priority_a: assert property (@(posedge clk_sys) disable iff (rst)
      $past(cmd_reg[CMD_SLOW] && cmd_reg[CMD_CATCH]) |-> ctrl.ref_down && !ctrl.ref_up)
      else $error("slow-down lost priority");

   mirror_bits_a: assert property (@(posedge clk_sys) disable iff (rst)
      drive_state_word[ST_ON2] == $past(cmd_reg[CMD_ON2]) && drive_state_word[ST_ON3] == $past(cmd_reg[CMD_ON3]))
      else $error("state bits 4/5 do not mirror command");

   enable_bit_a: assert property (@(posedge clk_sys) disable iff (rst)
      drive_state_word[ST_ENABLE] |-> $past(cmd_reg[2:0] == 3'h7 && !trip_reg))
      else $error("enable bit set without command");

   ready_bit_a: assert property (@(posedge clk_sys) disable iff (rst)
      $past(!ready_cmd || trip_reg) |-> !drive_state_word[ST_CTRL_READY])
      else $error("control ready while stopped or tripped");

   inhibit_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
      (cmd_reg[2:0] == 3'h6 && cmd_reg[CMD_VALID] && !reset_edge) |=> ##1 !drive_state_word[ST_INHIBIT])
      else $error("start inhibit not cleared");

   inhibit_set_a: assert property (@(posedge clk_sys) disable iff (rst)
      (!cmd_reg[CMD_ON2] || !cmd_reg[CMD_ON3]) |=> ##1 drive_state_word[ST_INHIBIT])
      else $error("start inhibit not set on stop");

   local_drop_a: assert property (@(posedge clk_sys) disable iff (rst)
      drive.local_keypad_stop |=> ##1 !drive_state_word[ST_BUS_CTRL])
      else $error("bus control kept after local stop");

   thermal_bit_a: assert property (@(posedge clk_sys) disable iff (rst)
      drive_state_word[ST_TIMER] == $past(drive.motor_thermal_pct > 8'h64 || drive.conv_thermal_pct > 8'h64))
      else $error("thermal bit wrong");

   setup_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
      (running && !setup_linked) |=> $stable(setup_reg)) else $error("set-up changed while running unlinked");

   // decode checks, one cycle behind the active word, quiet right after reset
   ramp_stop_a: assert property (@(posedge clk_sys) disable iff (rst)
      (!$past(rst) && $past(!cmd_reg[CMD_ON1])) |-> ctrl.ramp_stop)
      else $error("ramp stop missing");

   coast_off_a: assert property (@(posedge clk_sys) disable iff (rst)
      (!$past(rst) && $past(!cmd_reg[CMD_ON2])) |-> ctrl.coast_stop)
      else $error("coast stop missing");

   quick_off_a: assert property (@(posedge clk_sys) disable iff (rst)
      (!$past(rst) && $past(!cmd_reg[CMD_ON3])) |-> ctrl.quick_stop)
      else $error("quick stop missing");

   coast_bit_a: assert property (@(posedge clk_sys) disable iff (rst)
      (!$past(rst) && $past(cfg.coast_src == DPWI_SRC_SERIAL && !cmd_reg[CMD_NO_COAST])) |-> ctrl.coast_stop)
      else $error("bus coast bit ignored");

   quick_bit_a: assert property (@(posedge clk_sys) disable iff (rst)
      (!$past(rst) && $past(cfg.quick_src == DPWI_SRC_SERIAL && !cmd_reg[CMD_RAMP])) |-> ctrl.quick_stop)
      else $error("bus quick-stop bit ignored");

   hold_freq_a: assert property (@(posedge clk_sys) disable iff (rst)
      !$past(rst) |-> ctrl.hold_freq == $past(!cmd_reg[CMD_USE_RAMP]))
      else $error("hold frequency wrong");

   start_bit_a: assert property (@(posedge clk_sys) disable iff (rst)
      (!$past(rst) && $past(cfg.start_src == DPWI_SRC_SERIAL && !cmd_reg[CMD_START])) |-> ctrl.ramp_stop && !ctrl.run_enable)
      else $error("start bit low did not stop");

   relay_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
      ctrl.stop_relay |-> $past(cfg.stop_relay_en && drive.at_zero_freq))
      else $error("stop relay away from zero frequency");

   ref_down_a: assert property (@(posedge clk_sys) disable iff (rst)
      !$past(rst) |-> ctrl.ref_down == $past(cmd_reg[CMD_SLOW]))
      else $error("slow-down request wrong");

   ref_up_a: assert property (@(posedge clk_sys) disable iff (rst)
      ctrl.ref_up |-> $past(cmd_reg[CMD_CATCH]))
      else $error("catch-up without request");

   word_latch_a: assert property (@(posedge clk_sys) disable iff (rst)
      accept |=> cmd_reg == $past(drive_command_word))
      else $error("valid word not taken");

   setup_take_a: assert property (@(posedge clk_sys) disable iff (rst)
      (cfg.multi_setup && !running) |=> setup_reg == $past(setup_req))
      else $error("set-up request not taken at standstill");

   reverse_digital_a: assert property (@(posedge clk_sys) disable iff (rst)
      (!$past(rst) && $past(cfg.reverse_src == DPWI_SRC_DIGITAL)) |-> ctrl.reverse == $past(din.reverse))
      else $error("bus bit reversed in digital mode");

   at_ref_a: assert property (@(posedge clk_sys) disable iff (rst)
      !$past(rst) |-> drive_state_word[ST_AT_REF] == $past(drive.speed_at_ref))
      else $error("speed match bit wrong");

   freq_window_a: assert property (@(posedge clk_sys) disable iff (rst)
      !$past(rst) |-> drive_state_word[ST_FREQ_OK] ==
         $past(drive.output_freq >= cfg.warn_speed_low && drive.output_freq <= cfg.warn_speed_high))
      else $error("frequency window bit wrong");

   reply_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
      !$past(rst) |-> reply_strobe == $past(cmd_strobe))
      else $error("reply strobe not one cycle after telegram");

   bus_take_a: assert property (@(posedge clk_sys) disable iff (rst)
      (accept && drive.remote_site && !drive.local_keypad_stop && !drive.local_site_sel) |=> ##1 drive_state_word[ST_BUS_CTRL])
      else $error("bus control not taken");

   sequence trip_shown_s;
      trip_reg ##1 drive_state_word[ST_TRIP];
   endsequence

   trip_shown_a: assert property (@(posedge clk_sys) disable iff (rst)
      drive.fault_event |=> trip_shown_s)
      else $error("fault not shown as trip");

endmodule

// *** testbench/dpwi_master_model.sv ***
`timescale 1ns/1ns
module dpwi_master_model
   import dpwi_pkg::*;
(
   input  wire logic        clk_sys,
   output logic             cmd_strobe,
   output logic [15:0]      drive_command_word,
   input  wire logic [15:0] drive_state_word,
   input  wire logic        reply_strobe
);
   int          miss_count;
   logic [15:0] last_state;

   // bus idle at time zero
   initial begin
      cmd_strobe         = 1'b0;
      drive_command_word = 16'h0000;
      miss_count         = 0;
   end

   // one telegram; word is scrambled once released, reply awaited bounded
   task automatic send(input logic [15:0] word);
      int n;
      n                  = 0;
      cmd_strobe         = 1'b1;
      drive_command_word = word;
      @(posedge clk_sys);
      #1;
      cmd_strobe         = 1'b0;
      drive_command_word = ~word;
      while (reply_strobe !== 1'b1 && n < 4) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (n != 0) begin
         miss_count++;
         $display("unexpected reply delay at %0t: got %h expected %h", $time, n, 0);
      end
      last_state = drive_state_word;
   endtask
endmodule

// *** testbench/drive_profile_word_interpreter_test.sv ***
`timescale 1ns/1ns
module drive_profile_word_interpreter_test
   import dpwi_pkg::*;
;
   localparam logic [15:0] RUN = 16'h047F;
   logic         clk_sys;
   logic         rst;
   logic         cmd_strobe;
   logic [15:0]  drive_command_word;
   logic [15:0]  drive_state_word;
   logic         reply_strobe;
   dpwi_config_t cfg;
   dpwi_din_t    din;
   dpwi_drive_t  drive;
   dpwi_ctrl_t   ctrl;
   int           err_count;
   int           n_tests;
   logic [15:0]  sw;

   dpwi_top dut (
      .clk_sys            (clk_sys),
      .rst                (rst),
      .cmd_strobe         (cmd_strobe),
      .drive_command_word (drive_command_word),
      .cfg                (cfg),
      .din                (din),
      .drive              (drive),
      .drive_state_word   (drive_state_word),
      .reply_strobe       (reply_strobe),
      .ctrl               (ctrl)
   );

   dpwi_master_model master (
      .clk_sys            (clk_sys),
      .cmd_strobe         (cmd_strobe),
      .drive_command_word (drive_command_word),
      .drive_state_word   (drive_state_word),
      .reply_strobe       (reply_strobe)
   );

   // free-running system clock
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] mask);
      n_tests++;
      if (((got ^ exp) & mask) !== 16'h0000) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got & mask, exp & mask);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic send_wait(input logic [15:0] w, input int n);
      master.send(w);
      settle(n);
      sw = drive_state_word;
   endtask

   task automatic finish_test;
      err_count += master.miss_count;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // off bits, state mirrors and stop requests for all eight patterns
   task automatic test_off_bits;
      for (int i = 0; i < 8; i++) begin
         send_wait(16'h0478 | 16'(i), 1);
         check_word(sw, {10'h0, i[2], i[1], 1'b0, i == 7, 1'b0, i == 7}, 16'h0035);
         check_word({13'h0, ctrl.quick_stop, ctrl.coast_stop, ctrl.ramp_stop}, 16'(~i[2:0]), 16'h0007);
         check_bit(ctrl.stop_relay, i != 7);
      end
      $display("test off_bits done");
   endtask

   // bits 3..6 cleared one at a time, then all set
   task automatic test_levels;
      for (int k = 3; k < 8; k++) begin
         send_wait(RUN & ~(16'h0001 << k), 1);
         check_word({12'h0, ctrl.ramp_stop, ctrl.hold_freq, ctrl.quick_stop, ctrl.coast_stop},
                    (k < 7) ? (16'h0001 << (k - 3)) : 16'h0000, 16'h000F);
      end
      send_wait(RUN & ~16'h0040, 1);
      check_bit(ctrl.stop_relay, 1'b1);
      $display("test levels done");
   endtask

   // invalid words change nothing
   task automatic test_invalid;
      send_wait((RUN | 16'h0300) & ~16'h0010, 1);
      check_word({14'h0, ctrl.jog2, ctrl.jog1}, 16'h0003, 16'h0003);
      send_wait(16'h0300 | 16'h0008, 2);
      check_word({14'h0, ctrl.jog2, ctrl.jog1}, 16'h0003, 16'h0003);
      check_word(sw, 16'h0035, 16'h0035);
      send_wait(RUN | 16'h0300, 1);
      check_word({14'h0, ctrl.jog2, ctrl.jog1}, 16'h0000, 16'h0003);
      send_wait(16'h0716, 1);
      check_word({14'h0, ctrl.jog2, ctrl.jog1}, 16'h0000, 16'h0003);
      $display("test invalid done");
   endtask

   // slow-down and catch-up in all four combinations
   task automatic test_ref;
      for (int i = 0; i < 4; i++) begin
         send_wait(RUN | 16'(i << 11), 1);
         check_word({14'h0, ctrl.ref_up, ctrl.ref_down}, (i == 2) ? 16'h2 : 16'(i & 1), 16'h3);
      end
      $display("test ref done");
   endtask

   // set-up selection, then running change refused until linked
   task automatic test_setup;
      for (int i = 0; i < 4; i++) begin
         send_wait(RUN | 16'(i << 13), 2);
         check_word({14'h0, ctrl.active_setup}, 16'(i), 16'h3);
      end
      drive.at_zero_freq = 1'b0;
      send_wait(RUN | 16'h2000, 2);
      check_word({14'h0, ctrl.active_setup}, 16'h3, 16'h3);
      cfg.setup_link_select[3] = 2'h1;
      send_wait(RUN | 16'h2000, 2);
      check_word({14'h0, ctrl.active_setup}, 16'h1, 16'h3);
      drive.at_zero_freq = 1'b1;
      $display("test setup done");
   endtask

   // reversing source modes against the digital input
   task automatic test_reverse;
      for (int s = 0; s < 4; s++) begin
         for (int d = 0; d < 2; d++) begin
            cfg.reverse_src = dpwi_src_t'(s[1:0]);
            din.reverse     = d[0];
            send_wait(RUN | 16'h8000, 1);
            check_bit(ctrl.reverse, (s == 1 || s == 2) ? 1'b1 : d[0]);
         end
      end
      cfg.reverse_src = DPWI_SRC_SERIAL;
      din.reverse     = 1'b0;
      $display("test reverse done");
   endtask

   // trip, edge reset, steady reset ignored
   task automatic test_trip;
      send_wait(RUN, 0);
      drive.fault_event = 1'b1;
      settle(1);
      drive.fault_event = 1'b0;
      settle(2);
      check_word(drive_state_word, 16'h0008, 16'h000D);
      check_word({14'h0, ctrl.run_enable, ctrl.coast_stop}, 16'h1, 16'h3);
      send_wait(RUN | 16'h0080, 0);
      check_bit(ctrl.fault_reset, 1'b1);
      settle(1);
      check_bit(ctrl.fault_reset, 1'b0);
      send_wait(RUN | 16'h0080, 3);
      check_word(sw, 16'h0000, 16'h0008);
      drive.fault_event = 1'b1;
      settle(1);
      drive.fault_event = 1'b0;
      send_wait(RUN | 16'h0080, 3);
      check_word(sw, 16'h0008, 16'h0008);
      send_wait(RUN, 0);
      send_wait(RUN | 16'h0080, 3);
      check_word(sw, 16'h0005, 16'h000D);
      $display("test trip done");
   endtask

   // start inhibit cleared and set again
   task automatic test_inhibit;
      send_wait(16'h0406, 3);
      check_word(sw, 16'h0000, 16'h0040);
      send_wait(RUN & ~16'h0002, 2);
      check_word(sw, 16'h0040, 16'h0040);
      send_wait(16'h0406, 3);
      check_word(sw, 16'h0000, 16'h0040);
      $display("test inhibit done");
   endtask

   // speed match, bus control, frequency window, thermal timers
   task automatic test_status;
      drive.speed_at_ref      = 1'b1;
      drive.output_freq       = 16'sh0032;
      drive.motor_thermal_pct = 8'h64;
      drive.warning           = 1'b1;
      drive.overload_stop     = 1'b1;
      drive.voltage_exceeded  = 1'b1;
      drive.torque_exceeded   = 1'b1;
      send_wait(RUN, 2);
      check_word(sw, 16'h7780, 16'hF780);
      check_bit(ctrl.run_enable, 1'b1);
      drive.warning           = 1'b0;
      drive.overload_stop     = 1'b0;
      drive.voltage_exceeded  = 1'b0;
      drive.torque_exceeded   = 1'b0;
      drive.speed_at_ref      = 1'b0;
      drive.output_freq       = -16'sh0065;
      drive.conv_thermal_pct  = 8'h65;
      drive.local_keypad_stop = 1'b1;
      settle(3);
      check_word(drive_state_word, 16'h8000, 16'hF780);
      drive.local_keypad_stop = 1'b0;
      drive.output_freq       = 16'sh0065;
      drive.conv_thermal_pct  = 8'h00;
      send_wait(RUN, 2);
      check_word(sw, 16'h0200, 16'h8600);
      $display("test status done");
   endtask

   // stimulus sequence
   initial begin
      err_count = 0;
      n_tests   = 0;
      rst       = 1'b1;
      cfg       = '0;
      din       = '0;
      drive     = '0;
      cfg.coast_src = DPWI_SRC_SERIAL;
      cfg.quick_src = DPWI_SRC_SERIAL;
      cfg.start_src = DPWI_SRC_SERIAL;
      cfg.reverse_src = DPWI_SRC_SERIAL;
      cfg.setup_src = DPWI_SRC_SERIAL;
      cfg.multi_setup = 1'b1;
      cfg.stop_relay_en = 1'b1;
      cfg.warn_speed_low = -16'sh0064;
      cfg.warn_speed_high = 16'sh0064;
      din.coast_ok = 1'b1;
      din.quick_ok = 1'b1;
      drive.control_ready = 1'b1;
      drive.power_ready = 1'b1;
      drive.remote_site = 1'b1;
      drive.at_zero_freq = 1'b1;
      settle(5);
      rst = 1'b0;
      settle(2);
      check_word(drive_state_word, 16'h0040, 16'h007D);
      test_off_bits();
      test_levels();
      test_invalid();
      test_ref();
      test_setup();
      test_reverse();
      test_trip();
      test_inhibit();
      test_status();
      finish_test();
   end

   // cuts a hang short
   initial begin
      #400000;
      err_count++;
      finish_test();
   end
endmodule
